/* File: core/link_status_led_driver.sv */
// status indicator driver with mask, mode, blink and stretch logic
//
// Function
// - five indicator outputs, each with its own function selection
// - per-indicator control words share one control register
// - a source reaches an indicator only when its mask bit is 1
// - several set mask bits are ORed together
// - the source status register drives indicators through the masks
// - each indicator has its own output enable
// - mode 00 holds the indicator off; 11 is reserved
// - mode 01 blinks on selected sources with a four-bit cycle field
// - mode 10 lights steadily while selected sources are asserted
// - source bit 1 is receive activity, bit 2 transmit activity
// - both activity masks set shows combined receive and transmit
// - source bits 4:3 give 11 for 1000M link, 10 for 100M
// - source bit 5 reads 1; bit 7 shows 10G link up
// - second source register: bit 2 2.5G up, bit 3 5G up
// - link status indicator mask starts at 0x0040 showing link
// - control registers apply at 10G, 1000M and 100M
// - default behaviour applies only when the strap is sampled low after reset
// - default behaviour at 10G, 5G and 2.5G
// - default behaviour at 1000M and 100M
`timescale 1ns/10ps
`default_nettype none

module link_status_led_driver #(
  parameter int TICK_CYCLES = indicator_pkg::MS_CYCLES
) (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  // management register port
  input  wire logic [15:0] reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [15:0] reg_wdata_i,
  output logic      [15:0] reg_rdata_o,
  output logic             reg_ack_o,
  // status sources from the transceiver core
  input  wire logic        rx_act_i,
  input  wire logic        tx_act_i,
  input  wire logic        link_1g_i,
  input  wire logic        link_100m_i,
  input  wire logic        link_10g_i,
  input  wire logic        link_5g_i,
  input  wire logic        link_2g5_i,
  input  wire logic        master_i,
  input  wire logic        training_i,
  // default strap pin, low selects default behaviour
  input  wire logic        default_strap_i,
  // indicator pins
  output logic [4:0]       indicator_o,
  output logic [4:0]       indicator_oe_o
);

  localparam int N = indicator_pkg::NUM_IND;

  function automatic logic [7:0] blink_reload(input logic [3:0] per);
    blink_reload = 8'(({4'h0, per} + 8'h01)
                   * 8'(indicator_pkg::BLINK_UNIT_MS) - 8'h01);
  endfunction : blink_reload

  // registers
  logic [15:0] mask_r [N];
  logic [15:0] blink_cfg_r [N];
  logic [15:0] indicator_control_word_r;
  logic [15:0] src_r;
  logic [15:0] src_two_r;

  // ms tick
  logic [17:0] tick_cnt_r;
  logic        tick_r;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      tick_cnt_r <= 18'h00000;
      tick_r     <= 1'b0;
    end else if (tick_cnt_r == 18'(TICK_CYCLES - 1)) begin
      tick_cnt_r <= 18'h00000;
      tick_r     <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 18'h00001;
      tick_r     <= 1'b0;
    end
  end

  // activity stretch
  logic [7:0] rx_str_r;
  logic [7:0] tx_str_r;
  logic       rx_long;
  logic       tx_long;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rx_str_r <= 8'h00;
      tx_str_r <= 8'h00;
    end else begin
      if (rx_act_i)
        rx_str_r <= 8'(indicator_pkg::STRETCH_MS);
      else if (tick_r && rx_str_r != 8'h00)
        rx_str_r <= rx_str_r - 8'h01;
      if (tx_act_i)
        tx_str_r <= 8'(indicator_pkg::STRETCH_MS);
      else if (tick_r && tx_str_r != 8'h00)
        tx_str_r <= tx_str_r - 8'h01;
    end
  end

  assign rx_long = rx_act_i | (rx_str_r != 8'h00);
  assign tx_long = tx_act_i | (tx_str_r != 8'h00);

  // source status registers
  logic [1:0] speed;
  logic       link_any;
  logic       link_hi;

  assign link_hi  = link_10g_i | link_5g_i | link_2g5_i;
  assign link_any = link_hi | link_1g_i | link_100m_i;
  assign speed    = link_1g_i   ? indicator_pkg::SPEED_1G :
                    link_100m_i ? indicator_pkg::SPEED_100M :
                                  indicator_pkg::SPEED_NONE;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      src_r     <= 16'h0000;
      src_two_r <= 16'h0000;
    end else begin
      src_r <= 16'h0000;
      src_r[indicator_pkg::SRC_RX_BIT]  <= rx_act_i;
      src_r[indicator_pkg::SRC_TX_BIT]  <= tx_act_i;
      src_r[indicator_pkg::SRC_SPEED_LSB +: 2] <= speed;
      src_r[indicator_pkg::SRC_ONE_BIT] <= 1'b1;
      src_r[indicator_pkg::SRC_10G_BIT] <= link_10g_i;
      src_two_r <= 16'h0000;
      src_two_r[indicator_pkg::SRC2_2G5_BIT] <= link_2g5_i;
      src_two_r[indicator_pkg::SRC2_5G_BIT]  <= link_5g_i;
    end
  end

  // strap capture
  logic         strap_s1_r;
  logic         strap_s2_r;
  logic         strap_s3_r;
  logic         default_on_r;
  logic [1:0]   fill_r;
  indicator_pkg::strap_state_t strap_state_r;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      strap_s1_r <= 1'b1;
      strap_s2_r <= 1'b1;
      strap_s3_r <= 1'b1;
    end else begin
      strap_s1_r <= default_strap_i;
      strap_s2_r <= strap_s1_r;
      strap_s3_r <= strap_s2_r;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      strap_state_r <= indicator_pkg::STRAP_SETTLE;
      default_on_r  <= 1'b0;
      fill_r        <= 2'h0;
    end else begin
      case (strap_state_r)
        indicator_pkg::STRAP_SETTLE: begin
          // let the pin level reach the third flop before trusting it
          if (fill_r != 2'h3) begin
            fill_r <= fill_r + 2'h1;
          end else if (strap_s2_r == strap_s3_r) begin
            default_on_r  <= ~strap_s3_r;
            strap_state_r <= indicator_pkg::STRAP_DONE;
          end
        end
        default: begin
          strap_state_r <= indicator_pkg::STRAP_DONE;
        end
      endcase
    end
  end

  // register writes
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      for (int i = 0; i < N; i++) begin
        mask_r[i]      <= (i == indicator_pkg::LINK_IND) ?
                          indicator_pkg::LINK_MASK_RST :
                          indicator_pkg::MASK_RST;
        blink_cfg_r[i] <= indicator_pkg::BLINK_RST;
      end
      indicator_control_word_r <= indicator_pkg::CTRL_RST;
    end else if (reg_wr_i) begin
      if (reg_addr_i == indicator_pkg::OFS_CTRL) begin
        indicator_control_word_r <= reg_wdata_i;
      end else begin
        for (int i = 0; i < N; i++) begin
          if (reg_addr_i == indicator_pkg::OFS_MASK_FIRST + 16'(i))
            mask_r[i] <= reg_wdata_i;
          else if (reg_addr_i == indicator_pkg::OFS_BLINK_FIRST + 16'(i))
            blink_cfg_r[i] <= reg_wdata_i;
        end
      end
    end
  end

  // register reads, one cycle answer, unmapped reads zero
  logic [15:0] rd_data;

  always_comb begin
    rd_data = 16'h0000;
    if (reg_addr_i == indicator_pkg::OFS_CTRL) begin
      rd_data = indicator_control_word_r;
    end else if (reg_addr_i == indicator_pkg::OFS_SRC) begin
      rd_data = src_r;
    end else if (reg_addr_i == indicator_pkg::OFS_SRC_TWO) begin
      rd_data = src_two_r;
    end else begin
      for (int i = 0; i < N; i++) begin
        if (reg_addr_i == indicator_pkg::OFS_MASK_FIRST + 16'(i))
          rd_data = mask_r[i];
        else if (reg_addr_i == indicator_pkg::OFS_BLINK_FIRST + 16'(i))
          rd_data = blink_cfg_r[i];
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      reg_rdata_o <= 16'h0000;
      reg_ack_o   <= 1'b0;
    end else begin
      reg_rdata_o <= reg_rd_i ? rd_data : 16'h0000;
      reg_ack_o   <= reg_rd_i | reg_wr_i;
    end
  end

  // per indicator selection and mode
  typedef indicator_pkg::indicator_mode_t indicator_mode_t;

  logic [N-1:0]    want;
  logic [N-1:0]    enable;
  indicator_mode_t mode [N];
  logic [15:0]     src_eff [N];
  logic [N-1:0]    phase_r;
  logic [7:0]      blink_cnt_r [N];

  always_comb begin
    for (int i = 0; i < N; i++) begin
      src_eff[i] = src_r;
      src_eff[i][indicator_pkg::SRC_LINK_BIT] = link_any;
      if (blink_cfg_r[i][indicator_pkg::BLINK_STR_BIT]) begin
        src_eff[i][indicator_pkg::SRC_RX_BIT] = rx_long;
        src_eff[i][indicator_pkg::SRC_TX_BIT] = tx_long;
      end
      want[i]   = |(mask_r[i] & src_eff[i]);
      mode[i]   = indicator_mode_t'(indicator_control_word_r[
                  i*indicator_pkg::CTRL_FIELD_W
                  + indicator_pkg::CTRL_MODE_LSB +: 2]);
      enable[i] = ~indicator_control_word_r[
                  i*indicator_pkg::CTRL_FIELD_W
                  + indicator_pkg::CTRL_OE_BIT];
    end
    if (default_on_r) begin
      want[0]   = link_hi ? master_i : link_1g_i;
      mode[0]   = indicator_pkg::MODE_ON;
      want[1]   = training_i | link_5g_i | link_2g5_i
                  | link_1g_i | link_100m_i;
      mode[1]   = training_i ? indicator_pkg::MODE_BLINK
                             : indicator_pkg::MODE_ON;
      want[2]   = rx_long | tx_long;
      mode[2]   = indicator_pkg::MODE_BLINK;
      want[4]   = link_hi;
      mode[4]   = indicator_pkg::MODE_ON;
      enable[0] = 1'b1;
      enable[1] = 1'b1;
      enable[2] = 1'b1;
      enable[4] = 1'b1;
    end
  end

  // blink engines restart with the indicator lit
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      for (int i = 0; i < N; i++) begin
        phase_r[i]     <= 1'b1;
        blink_cnt_r[i] <= 8'h00;
      end
    end else begin
      for (int i = 0; i < N; i++) begin
        if (!want[i]) begin
          phase_r[i]     <= 1'b1;
          blink_cnt_r[i] <= blink_reload(blink_cfg_r[i][3:0]);
        end else if (tick_r) begin
          if (blink_cnt_r[i] == 8'h00) begin
            phase_r[i]     <= ~phase_r[i];
            blink_cnt_r[i] <= blink_reload(blink_cfg_r[i][3:0]);
          end else begin
            blink_cnt_r[i] <= blink_cnt_r[i] - 8'h01;
          end
        end
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      indicator_o    <= 5'h00;
      indicator_oe_o <= 5'h00;
    end else begin
      for (int i = 0; i < N; i++) begin
        indicator_oe_o[i] <= enable[i];
        case (mode[i])
          indicator_pkg::MODE_BLINK:
            indicator_o[i] <= want[i] & phase_r[i];
          indicator_pkg::MODE_ON:
            indicator_o[i] <= want[i];
          default:
            indicator_o[i] <= 1'b0;
        endcase
      end
    end
  end

endmodule : link_status_led_driver

`default_nettype wire

/* File: core/indicator_pkg.sv */
// constants and types of the status indicator driver
package indicator_pkg;

  localparam int NUM_IND = 5;

  // timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int MS_NS         = 1000000;
  localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
  localparam int STRETCH_MS    = 20;
  localparam int BLINK_UNIT_MS = 16;

  // register offsets inside management device 1
  localparam logic [15:0] OFS_MASK_FIRST  = 16'hA832;
  localparam logic [15:0] OFS_LINK_MASK   = 16'hA835;
  localparam logic [15:0] OFS_CTRL        = 16'hA83B;
  localparam logic [15:0] OFS_SRC         = 16'hA83C;
  localparam logic [15:0] OFS_SRC_TWO     = 16'hA83D;
  localparam logic [15:0] OFS_BLINK_FIRST = 16'hA841;

  // reset values
  localparam logic [15:0] MASK_RST      = 16'h0000;
  localparam logic [15:0] LINK_MASK_RST = 16'h0040;
  localparam logic [15:0] CTRL_RST      = 16'h1849;
  localparam logic [15:0] BLINK_RST     = 16'h0013;

  // index of the link status indicator
  localparam int LINK_IND = 3;

  // field positions
  localparam int CTRL_FIELD_W   = 3;
  localparam int CTRL_OE_BIT    = 0;
  localparam int CTRL_MODE_LSB  = 1;
  localparam int BLINK_PER_LSB  = 0;
  localparam int BLINK_STR_BIT  = 4;
  localparam int SRC_RX_BIT     = 1;
  localparam int SRC_TX_BIT     = 2;
  localparam int SRC_SPEED_LSB  = 3;
  localparam int SRC_ONE_BIT    = 5;
  localparam int SRC_LINK_BIT   = 6;
  localparam int SRC_10G_BIT    = 7;
  localparam int SRC2_2G5_BIT   = 2;
  localparam int SRC2_5G_BIT    = 3;

  localparam logic [1:0] SPEED_1G   = 2'h3;
  localparam logic [1:0] SPEED_100M = 2'h2;
  localparam logic [1:0] SPEED_NONE = 2'h0;

  typedef enum logic [1:0] {
    MODE_OFF   = 2'b00,
    MODE_BLINK = 2'b01,
    MODE_ON    = 2'b10,
    MODE_RSVD  = 2'b11
  } indicator_mode_t;

  typedef enum logic [1:0] {
    STRAP_SETTLE = 2'b00,
    STRAP_DONE   = 2'b01
  } strap_state_t;

endpackage : indicator_pkg

/* File: tb/link_status_led_driver_properties.sv */
// port assertions of the status indicator driver
`timescale 1ns/10ps
`default_nettype none
module indicator_checker #(
  parameter int TICK_CYCLES = 4
) (
  input wire logic        mclk_i,
  input wire logic        rst_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic        reg_ack_o,
  input wire logic        link_1g_i,
  input wire logic        link_10g_i,
  input wire logic        link_5g_i,
  input wire logic [4:0]  indicator_o,
  input wire logic [4:0]  indicator_oe_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  sequence rd_src;
    reg_rd_i && reg_addr_i == indicator_pkg::OFS_SRC;
  endsequence
  sequence rd_src2;
    reg_rd_i && reg_addr_i == indicator_pkg::OFS_SRC_TWO;
  endsequence
  ack_follows_a: assert property ((reg_wr_i || reg_rd_i) |=> reg_ack_o)
    else $error("no ack after request");
  ack_cause_a: assert property (reg_ack_o |-> $past(reg_wr_i || reg_rd_i))
    else $error("ack without request");
  rdata_idle_a: assert property (!reg_ack_o |-> reg_rdata_o == 16'h0000)
    else $error("read data outside ack");
  src_fixed_a: assert property (rd_src |=> reg_rdata_o[5] &&
    reg_rdata_o[15:8] == 8'h00 && !reg_rdata_o[0] && !reg_rdata_o[6])
    else $error("fixed source bits wrong");
  ten_link_a: assert property (link_10g_i [*3] ##0 rd_src |=>
    reg_rdata_o[7]) else $error("10G link bit low");
  speed_one_a: assert property (link_1g_i [*3] ##0 rd_src |=>
    reg_rdata_o[4:3] == 2'b11) else $error("1G speed code wrong");
  five_up_a: assert property (link_5g_i [*3] ##0 rd_src2 |=>
    reg_rdata_o[3]) else $error("5G link bit low");
  unmapped_a: assert property (reg_rd_i && reg_addr_i == 16'h0000 |=>
    reg_rdata_o == 16'h0000) else $error("unmapped read not zero");
  reset_quiet_a: assert property (@(posedge mclk_i) disable iff (1'b0)
    rst_i |=> indicator_o == 5'h00 && indicator_oe_o == 5'h00)
    else $error("indicators active after reset");
endmodule : indicator_checker

bind link_status_led_driver indicator_checker #(
  .TICK_CYCLES(TICK_CYCLES)
) i_chk (
  .mclk_i(mclk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .reg_ack_o(reg_ack_o), .link_1g_i(link_1g_i), .link_10g_i(link_10g_i),
  .link_5g_i(link_5g_i), .indicator_o(indicator_o),
  .indicator_oe_o(indicator_oe_o)
);
`default_nettype wire

/* File: tb/link_status_led_driver_tb.sv */
// self-checking bench of the status indicator driver
`timescale 1ns/10ps
`default_nettype none
module link_status_led_driver_tb;
  logic [15:0] reg_addr_i, reg_wdata_i, reg_rdata_o, rd_v;
  logic        mclk_i, rst_i, reg_wr_i, reg_rd_i, reg_ack_o, prev;
  logic        rx_act_i, tx_act_i, link_1g_i, link_100m_i, link_10g_i;
  logic        link_5g_i, link_2g5_i, master_i, training_i, default_strap_i;
  logic [4:0]  indicator_o, indicator_oe_o;
  logic [31:0] seed;
  int          mismatches, n_tests, ctrl, k, i, f, lit, rises;

  link_status_led_driver #(.TICK_CYCLES(4)) i_dut (
    .mclk_i(mclk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .reg_ack_o(reg_ack_o),
    .rx_act_i(rx_act_i), .tx_act_i(tx_act_i), .link_1g_i(link_1g_i),
    .link_100m_i(link_100m_i), .link_10g_i(link_10g_i),
    .link_5g_i(link_5g_i), .link_2g5_i(link_2g5_i), .master_i(master_i),
    .training_i(training_i), .default_strap_i(default_strap_i),
    .indicator_o(indicator_o), .indicator_oe_o(indicator_oe_o));

  initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  // source register as the rules lay it out
  function automatic logic [15:0] src_exp();
    return {8'h00, link_10g_i, 2'b01, link_1g_i | link_100m_i, link_1g_i,
            tx_act_i, rx_act_i, 1'b0};
  endfunction : src_exp

  function automatic logic [4:0] oe_exp(input int c);
    for (int j = 0; j < 5; j++)
      oe_exp[j] = !c[3*j];
  endfunction : oe_exp

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : cyc

  // one register access, strobe held for exactly one edge
  task automatic acc(input logic w, input logic [15:0] a, d);
    @(posedge mclk_i);
    #1;
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = w;
    reg_rd_i = !w;
    cyc(1);
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    rd_v = reg_rdata_o;
    chk(16'(reg_ack_o), 16'h0001);
  endtask : acc

  task automatic rdc(input logic [15:0] a, exp);
    acc(1'b0, a, 16'h0000);
    chk(rd_v, exp);
  endtask : rdc

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    #100000;
    mismatches++;
    $display("[ERR] %0t watchdog expired", $time);
    wrap_up();
  end

  initial begin
    {reg_addr_i, reg_wdata_i, reg_wr_i, reg_rd_i, rx_act_i, tx_act_i} = '0;
    {link_1g_i, link_100m_i, link_10g_i, link_5g_i, link_2g5_i} = '0;
    {master_i, training_i, mismatches, n_tests} = '0;
    default_strap_i = 1'b1;
    rst_i = 1'b1;
    seed = 32'hBCE8;
    ctrl = 16'h1849;
    repeat (8) @(posedge mclk_i);
    #1;
    rst_i = 1'b0;
    chk(16'({indicator_o, indicator_oe_o}), 16'h0000);
    cyc(9);
    chk(16'(indicator_oe_o), 16'h0008);
    rdc(16'hA835, 16'h0040);
    rdc(16'hA83B, 16'h1849);
    rdc(16'hA832, 16'h0000);
    rdc(16'h0000, 16'h0000);
    $display("reset test done");
    for (k = 0; k < 8; k++) begin
      seed = xs(seed);
      {rx_act_i, tx_act_i, link_10g_i, link_5g_i, link_2g5_i} = seed[4:0];
      link_1g_i = seed[5];
      link_100m_i = seed[6] & !seed[5];
      cyc(3);
      rdc(16'hA83C, src_exp());
      rdc(16'hA83D, {12'h000, link_5g_i, link_2g5_i, 2'b00});
    end
    acc(1'b1, 16'hA83C, 16'hFFFF);
    rdc(16'hA83C, src_exp());
    $display("source test done");
    {rx_act_i, tx_act_i, link_5g_i, link_2g5_i, link_100m_i} = '0;
    for (i = 0; i < 5; i++) begin
      acc(1'b1, 16'(16'hA832 + i), 16'h0020);
      for (f = 0; f < 8; f++) begin
        rdc(16'hA83B, 16'(ctrl));
        ctrl = (ctrl & ~(7 << 3*i)) | (f << 3*i);
        acc(1'b1, 16'hA83B, 16'(ctrl));
        cyc(4);
        chk(16'(indicator_oe_o), 16'(oe_exp(ctrl)));
        if (f % 2 == 0 && f != 2)
          chk(16'(indicator_o[i]), 16'(f == 4));
      end
    end
    $display("mode test done");
    ctrl = (ctrl & ~7) | 4;
    acc(1'b1, 16'hA83B, 16'(ctrl));
    acc(1'b1, 16'hA832, 16'h0090);
    for (k = 0; k < 5; k++) begin
      {link_1g_i, link_10g_i} = 2'(k == 4 ? 3 : k);
      if (k == 4)
        acc(1'b1, 16'hA832, 16'h0000);
      cyc(4);
      chk(16'(indicator_o[0]), 16'(k % 4 != 0));
    end
    {link_1g_i, link_10g_i} = '0;
    acc(1'b1, 16'hA832, 16'h0006);
    acc(1'b1, 16'hA841, 16'h0013);
    for (k = 0; k < 2; k++) begin
      {tx_act_i, rx_act_i} = 2'(k + 1);
      cyc(1);
      {tx_act_i, rx_act_i} = '0;
      cyc(3);
      chk(16'(indicator_o[0]), 16'h0001);
      cyc(60);
      chk(16'(indicator_o[0]), 16'h0001);
      cyc(40);
      chk(16'(indicator_o[0]), 16'h0000);
    end
    $display("mask test done");
    acc(1'b1, 16'hA841, 16'h0010);
    rdc(16'hA841, 16'h0010);
    acc(1'b1, 16'hA832, 16'h0020);
    ctrl = (ctrl & ~7) | 2;
    acc(1'b1, 16'hA83B, 16'(ctrl));
    {lit, rises} = '0;
    prev = indicator_o[0];
    for (k = 0; k < 512; k++) begin
      cyc(1);
      lit += int'(indicator_o[0]);
      rises += int'(indicator_o[0] & ~prev);
      prev = indicator_o[0];
    end
    chk(16'(lit >= 224 && lit <= 288 && rises >= 3 && rises <= 5), 1);
    $display("blink test done");
    // the strap is only taken after a reset
    default_strap_i = 1'b0;
    rst_i = 1'b1;
    cyc(2);
    rst_i = 1'b0;
    acc(1'b1, 16'hA83B, 16'h1249);
    for (k = 0; k < 4; k++) begin
      {link_10g_i, link_1g_i, link_100m_i, master_i} = 4'(16'h2489 >> 4*k);
      cyc(10);
      chk(16'({indicator_o[4], indicator_o[1], indicator_o[0]}),
          16'(4'(16'h2345 >> 4*k)));
      chk(16'(indicator_oe_o & 5'h17), 16'h0017);
    end
    $display("strap test done");
    wrap_up();
  end
endmodule : link_status_led_driver_tb
`default_nettype wire
